// ---- host_ctl_model.sv ----
/*
 * Host management controller model: byte reads and writes on the plain
 * request port. Assumes MCLK is the block's clock; one request per put, four per set_pw.
 */
`timescale 1ns/1ps
module host_ctl_model (
   input  wire logic           MCLK,
   output modctl_pkg::mgmt_req_s REQ
);
   import modctl_pkg::*;

   initial REQ = '0;

   // Released address and data go inverted, strobes drop to zero, so stale values cannot pass for a match
   task automatic put(input logic [7:0] a, input logic [7:0] d,
                      input logic w);
      @(posedge MCLK);
      REQ <= '{addr: a, wdata: d, wr: w, rd: !w};
      @(posedge MCLK);
      REQ <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
   endtask

   // Most significant byte first, commit byte last
   task automatic set_pw(input logic [7:0] base, input logic [31:0] v);
      for (int i = 0; i < PW_BYTES; i++) begin
         put(base + i[7:0], v[31 - 8 * i -: 8], 1'b1);
      end
   endtask
endmodule // host_ctl_model

// ---- modctl_pkg.sv ----
/*
 * Constants and carriers for the transceiver control, mask and password
 * register slice. Assumes byte-wide management accesses on a plain port.
 */
package modctl_pkg;

   localparam logic [7:0]  OFS_LANE_TX_OFF    = 8'h56;
   localparam logic [7:0]  OFS_RSVD_LO        = 8'h57;
   localparam logic [7:0]  OFS_RSVD_HI        = 8'h5c;
   localparam logic [7:0]  OFS_POWER_MODE     = 8'h5d;
   localparam logic [7:0]  OFS_RX_LOSS_MASK   = 8'h64;
   localparam logic [7:0]  OFS_TX_FAULT_MASK  = 8'h65;
   localparam logic [7:0]  OFS_TEMP_MASK      = 8'h67;
   localparam logic [7:0]  OFS_VCC_MASK       = 8'h68;
   localparam logic [7:0]  OFS_PW_CHANGE      = 8'h77;
   localparam logic [7:0]  OFS_PW_ENTRY       = 8'h7b;
   localparam logic [7:0]  OFS_PAGE_SELECT    = 8'h7f;
   localparam logic [7:0]  OFS_PW_STATUS      = 8'h6a;

   localparam int          PW_BYTES           = 4;
   localparam int          BIT_POWER_OVERRIDE = 0;
   localparam int          BIT_POWER_LOW      = 1;
   localparam int          PW_MAKER_BIT       = 31;
   localparam logic [7:0]  PAGE_USER          = 8'h02;

   localparam logic [7:0]  RESET_BYTE         = 8'h00;
   localparam logic [3:0]  LANE_MASK_FIELD    = 4'hf;
   localparam logic [7:0]  ALARM_MASK_FIELD   = 8'hf0;
   localparam logic [31:0] PW_RESET           = 32'h0000_0000;
   localparam logic [31:0] HOST_PW_DEFAULT    = 32'h0000_1011;

   // Event inputs, grouped by mask byte
   typedef struct packed {
      logic [3:0] rx_loss;
      logic [3:0] tx_fault;
      logic [3:0] temp;      // high alarm, low alarm, high warn, low warn
      logic [3:0] vcc;
   } events_s;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } mgmt_req_s;

endpackage

// ---- module_ctrl_mask_password_regs.sv ----
/*
 * Control, interrupt mask, password and page select byte registers.
 * Assumes a host-side protocol engine that turns serial management traffic
 * into single-cycle byte reads and writes on MCLK; event inputs are raw.
 */
`timescale 1ns/1ps

// Functional notes
// - Byte 0x56 bits 3:0 are lane transmitter disables, read and write.
// - Bytes 0x57 to 0x5c ignore writes and read zero.
// - Power byte bit 1 requests low power; resets to zero.
// - Power byte bit 0 set makes bit 1 replace the low-power pin.
// - An event with its mask bit set never raises the interrupt.
// - An unmasked event drives the interrupt line low.
// - Receiver mask byte holds four lane loss masks in bits 3:0.
// - Transmitter mask byte holds four lane fault masks in bits 3:0.
// - Temperature mask byte holds four masks in bits 7:4.
// - Supply mask byte holds four masks in bits 7:4.
// - Password bytes are write-only and kept until reset or rewrite.
// - Lower page and upper pages 0, 2, 3 reads never need a password.
// - Writes to user page two may be gated by a valid host password.
// - Top bit of the entry area marks maker passwords versus host ones.
// - Host password starts at the fixed factory default value.
// - Correct current password lets change area set new host password.
// - Entry area clears to zero on power up and every reset.
module module_ctrl_mask_password_regs (
   input  wire logic                  MCLK,
   input  wire logic                  RESET,
   input  wire modctl_pkg::mgmt_req_s REQ,
   output logic [7:0]                 RDATA,
   input  wire logic                  LP_MODE_PIN,
   input  wire modctl_pkg::events_s   EVENTS,
   output logic [3:0]                 TX_OFF,
   output logic                       LOW_POWER,
   output logic                       INT_N,
   output logic [7:0]                 PAGE,
   output logic                       USER_PAGE_WRITE_OK
);
   import modctl_pkg::*;

   logic [3:0]  lane_tx_off_r;
   logic [1:0]  power_mode_ctrl_r;
   logic [3:0]  rx_signal_loss_mask_r;
   logic [3:0]  tx_fault_mask_r;
   logic [3:0]  temperature_mask_r;
   logic [3:0]  supply_voltage_mask_r;
   logic [7:0]  upper_page_select_r;
   logic [31:0] password_change_area_r;
   logic [31:0] password_entry_area_r;
   logic [31:0] host_password_r;
   logic [2:0]  lp_sync_r;
   logic        lp_pin_r;
   events_s     ev_s1_r;
   events_s     ev_s2_r;
   events_s     ev_s3_r;
   events_s     ev_agree_r;
   logic        int_n_r;
   logic        int_n_nxt;
   logic        host_pw_ok;
   logic        change_last;
   logic [7:0]  rdata_r;
   logic [7:0]  rdata_nxt;
   logic [1:0]  pw_idx;

   // Password byte order: lowest address is the most significant byte
   assign pw_idx = 2'(PW_BYTES - 1) - REQ.addr[1:0] + 2'(OFS_PW_CHANGE);

   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         lane_tx_off_r <= 4'h0;
      end else if (REQ.wr && REQ.addr == OFS_LANE_TX_OFF) begin
         lane_tx_off_r <= REQ.wdata[3:0];
      end
   end

   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         power_mode_ctrl_r <= 2'b00;
      end else if (REQ.wr && REQ.addr == OFS_POWER_MODE) begin
         power_mode_ctrl_r <= REQ.wdata[1:0];
      end
   end

   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         rx_signal_loss_mask_r <= 4'h0;
         tx_fault_mask_r       <= 4'h0;
         temperature_mask_r    <= 4'h0;
         supply_voltage_mask_r <= 4'h0;
      end else if (REQ.wr) begin
         if (REQ.addr == OFS_RX_LOSS_MASK) begin
            rx_signal_loss_mask_r <= REQ.wdata[3:0];
         end
         if (REQ.addr == OFS_TX_FAULT_MASK) begin
            tx_fault_mask_r <= REQ.wdata[3:0];
         end
         if (REQ.addr == OFS_TEMP_MASK) begin
            temperature_mask_r <= REQ.wdata[7:4];
         end
         if (REQ.addr == OFS_VCC_MASK) begin
            supply_voltage_mask_r <= REQ.wdata[7:4];
         end
      end
   end

   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         upper_page_select_r <= RESET_BYTE;
      end else if (REQ.wr && REQ.addr == OFS_PAGE_SELECT) begin
         upper_page_select_r <= REQ.wdata;
      end
   end

   // Write-only areas; held until reset or rewrite
   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         password_entry_area_r  <= PW_RESET;
         password_change_area_r <= PW_RESET;
      end else if (REQ.wr) begin
         if (REQ.addr >= OFS_PW_ENTRY && REQ.addr < OFS_PAGE_SELECT) begin
            password_entry_area_r[pw_idx*8 +: 8] <= REQ.wdata;
         end
         if (REQ.addr >= OFS_PW_CHANGE && REQ.addr < OFS_PW_ENTRY) begin
            password_change_area_r[pw_idx*8 +: 8] <= REQ.wdata;
         end
      end
   end

   // Maker passwords (top bit set) never match the host password
   assign host_pw_ok = !password_entry_area_r[PW_MAKER_BIT]
                       && password_entry_area_r == host_password_r;
   assign change_last = REQ.wr && REQ.addr == OFS_PW_ENTRY - 8'h01;

   // Commit on the last change byte, after the other three are in.
   // Trade-off: not retained through reset, no nonvolatile store here.
   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         host_password_r <= HOST_PW_DEFAULT;
      end else if (change_last && host_pw_ok) begin
         host_password_r <= {1'b0, password_change_area_r[30:8],
                             REQ.wdata};
      end
   end

   // Pin and event inputs are asynchronous: three stages, stages two and three must agree
   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         lp_sync_r <= 3'b000;
         lp_pin_r  <= 1'b0;
         ev_s1_r   <= '0;
         ev_s2_r   <= '0;
         ev_s3_r   <= '0;
         ev_agree_r <= '0;
      end else begin
         lp_sync_r <= {lp_sync_r[1:0], LP_MODE_PIN};
         if (lp_sync_r[1] == lp_sync_r[2]) begin
            lp_pin_r <= lp_sync_r[2];
         end
         ev_s1_r <= EVENTS;
         ev_s2_r <= ev_s1_r;
         ev_s3_r <= ev_s2_r;
         // Set on two agreeing highs, clear on two agreeing lows
         ev_agree_r <= events_s'((ev_s2_r & ev_s3_r)
                                 | (ev_agree_r & (ev_s2_r | ev_s3_r)));
      end
   end

   always_comb begin
      int_n_nxt = 1'b1;
      if (|(ev_agree_r.rx_loss & ~rx_signal_loss_mask_r)
          || |(ev_agree_r.tx_fault & ~tx_fault_mask_r)
          || |(ev_agree_r.temp & ~temperature_mask_r)
          || |(ev_agree_r.vcc & ~supply_voltage_mask_r)) begin
         int_n_nxt = 1'b0;
      end
   end

   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         int_n_r <= 1'b1;
      end else begin
         int_n_r <= int_n_nxt;
      end
   end

   // Password areas read as zero; no read is ever password gated
   always_comb begin
      rdata_nxt = 8'h00;
      case (REQ.addr)
         OFS_LANE_TX_OFF:   rdata_nxt = {4'h0, lane_tx_off_r};
         OFS_POWER_MODE:    rdata_nxt = {6'h00, power_mode_ctrl_r};
         OFS_RX_LOSS_MASK:  rdata_nxt = {4'h0, rx_signal_loss_mask_r};
         OFS_TX_FAULT_MASK: rdata_nxt = {4'h0, tx_fault_mask_r};
         OFS_TEMP_MASK:     rdata_nxt = {temperature_mask_r, 4'h0};
         OFS_VCC_MASK:      rdata_nxt = {supply_voltage_mask_r, 4'h0};
         OFS_PW_STATUS:     rdata_nxt = {7'h00, host_pw_ok};
         OFS_PAGE_SELECT:   rdata_nxt = upper_page_select_r;
         default:           rdata_nxt = 8'h00;
      endcase
   end

   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         rdata_r <= 8'h00;
      end else if (REQ.rd) begin
         rdata_r <= rdata_nxt;
      end
   end

   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         TX_OFF             <= 4'h0;
         LOW_POWER          <= 1'b0;
         PAGE               <= RESET_BYTE;
         USER_PAGE_WRITE_OK <= 1'b0;
      end else begin
         TX_OFF    <= lane_tx_off_r;
         LOW_POWER <= power_mode_ctrl_r[BIT_POWER_OVERRIDE] ?
                      power_mode_ctrl_r[BIT_POWER_LOW] : lp_pin_r;
         PAGE      <= upper_page_select_r;
         USER_PAGE_WRITE_OK <= host_pw_ok;
      end
   end

   assign RDATA = rdata_r;
   assign INT_N = int_n_r;

   a_override_power: assert property (@(posedge MCLK) disable iff (RESET)
      power_mode_ctrl_r[BIT_POWER_OVERRIDE] |=>
      LOW_POWER == $past(power_mode_ctrl_r[BIT_POWER_LOW]))
      else $error("Low power ignores override");

   a_masked_quiet: assert property (@(posedge MCLK) disable iff (RESET)
      (rx_signal_loss_mask_r == LANE_MASK_FIELD
       && tx_fault_mask_r == LANE_MASK_FIELD
       && {temperature_mask_r, supply_voltage_mask_r} == 8'hff) |=> INT_N)
      else $error("Interrupt raised while all masked");

   a_event_irq: assert property (@(posedge MCLK) disable iff (RESET)
      (ev_agree_r.rx_loss[0] && !rx_signal_loss_mask_r[0]) |=> !INT_N)
      else $error("Unmasked event gave no interrupt");

   a_lane_write: assert property (@(posedge MCLK) disable iff (RESET)
      (REQ.wr && REQ.addr == OFS_LANE_TX_OFF) |=> ##1
      TX_OFF == $past(REQ.wdata[3:0], 2))
      else $error("Lane disable not applied");

   a_reserved_zero: assert property (@(posedge MCLK) disable iff (RESET)
      (REQ.rd && REQ.addr >= OFS_RSVD_LO && REQ.addr <= OFS_RSVD_HI)
      |=> RDATA == 8'h00)
      else $error("Reserved byte reads nonzero");

   a_pw_readzero: assert property (@(posedge MCLK) disable iff (RESET)
      (REQ.rd && REQ.addr >= OFS_PW_CHANGE && REQ.addr < OFS_PAGE_SELECT)
      |=> RDATA == 8'h00)
      else $error("Password bytes readable");

   a_temp_field: assert property (@(posedge MCLK) disable iff (RESET)
      (REQ.rd && REQ.addr == OFS_TEMP_MASK) |=> RDATA[3:0] == 4'h0)
      else $error("Temperature reserved bits set");

   a_pw_change: assert property (@(posedge MCLK) disable iff (RESET)
      (change_last && host_pw_ok) |=> host_password_r[PW_MAKER_BIT] == 1'b0
      && host_password_r[7:0] == $past(REQ.wdata))
      else $error("Host password change wrong");

   a_page_sel: assert property (@(posedge MCLK) disable iff (RESET)
      (REQ.wr && REQ.addr == OFS_PAGE_SELECT) |=> ##1
      PAGE == $past(REQ.wdata, 2))
      else $error("Page select not applied");

   a_lane_rdback: assert property (@(posedge MCLK) disable iff (RESET)
      (REQ.rd && REQ.addr == OFS_LANE_TX_OFF)
      |=> RDATA == {4'h0, $past(lane_tx_off_r)})
      else $error("Lane disable byte reads wrong");

   a_tx_reset: assert property (@(posedge MCLK) disable iff (RESET)
      $fell(RESET) |-> TX_OFF == 4'h0)
      else $error("Lane disable not cleared by reset");

   a_power_rdback: assert property (@(posedge MCLK) disable iff (RESET)
      (REQ.rd && REQ.addr == OFS_POWER_MODE)
      |=> RDATA == {6'h00, $past(power_mode_ctrl_r)})
      else $error("Power byte reads wrong");

   a_power_default: assert property (@(posedge MCLK) disable iff (RESET)
      $fell(RESET) |-> !LOW_POWER && power_mode_ctrl_r == 2'b00)
      else $error("Low power set after reset");

   a_pin_follow: assert property (@(posedge MCLK) disable iff (RESET)
      !power_mode_ctrl_r[BIT_POWER_OVERRIDE] |=>
      LOW_POWER == $past(lp_pin_r))
      else $error("Low power ignores pin");

   a_masked_none: assert property (@(posedge MCLK) disable iff (RESET)
      (!(|(ev_agree_r.rx_loss & ~rx_signal_loss_mask_r))
       && !(|(ev_agree_r.tx_fault & ~tx_fault_mask_r))
       && !(|(ev_agree_r.temp & ~temperature_mask_r))
       && !(|(ev_agree_r.vcc & ~supply_voltage_mask_r))) |=> INT_N)
      else $error("Interrupt without unmasked event");

   a_unmasked_low: assert property (@(posedge MCLK) disable iff (RESET)
      (|(ev_agree_r.tx_fault & ~tx_fault_mask_r)
       || |(ev_agree_r.temp & ~temperature_mask_r)
       || |(ev_agree_r.vcc & ~supply_voltage_mask_r)) |=> !INT_N)
      else $error("Unmasked module event gave no interrupt");

   a_rx_rdback: assert property (@(posedge MCLK) disable iff (RESET)
      (REQ.rd && REQ.addr == OFS_RX_LOSS_MASK)
      |=> RDATA == {4'h0, $past(rx_signal_loss_mask_r)})
      else $error("Receiver mask byte reads wrong");

   a_tx_rdback: assert property (@(posedge MCLK) disable iff (RESET)
      (REQ.rd && REQ.addr == OFS_TX_FAULT_MASK)
      |=> RDATA == {4'h0, $past(tx_fault_mask_r)})
      else $error("Transmitter mask byte reads wrong");

   a_temp_rdback: assert property (@(posedge MCLK) disable iff (RESET)
      (REQ.rd && REQ.addr == OFS_TEMP_MASK)
      |=> RDATA[7:4] == $past(temperature_mask_r))
      else $error("Temperature mask byte reads wrong");

   a_vcc_rdback: assert property (@(posedge MCLK) disable iff (RESET)
      (REQ.rd && REQ.addr == OFS_VCC_MASK)
      |=> RDATA == {$past(supply_voltage_mask_r), 4'h0})
      else $error("Supply mask byte reads wrong");

   a_entry_hold: assert property (@(posedge MCLK) disable iff (RESET)
      !(REQ.wr && REQ.addr >= OFS_PW_ENTRY && REQ.addr < OFS_PAGE_SELECT)
      |=> $stable(password_entry_area_r))
      else $error("Entry area changed without write");

   a_change_hold: assert property (@(posedge MCLK) disable iff (RESET)
      !(REQ.wr && REQ.addr >= OFS_PW_CHANGE && REQ.addr < OFS_PW_ENTRY)
      |=> $stable(password_change_area_r))
      else $error("Change area changed without write");

   a_read_ungated: assert property (@(posedge MCLK) disable iff (RESET)
      (REQ.rd && REQ.addr == OFS_PAGE_SELECT && !host_pw_ok)
      |=> RDATA == $past(upper_page_select_r))
      else $error("Read gated by password");

   a_write_gate: assert property (@(posedge MCLK) disable iff (RESET)
      1'b1 |=> USER_PAGE_WRITE_OK == $past(host_pw_ok))
      else $error("User page write grant wrong");

   a_maker_never: assert property (@(posedge MCLK) disable iff (RESET)
      password_entry_area_r[PW_MAKER_BIT] |-> !host_pw_ok)
      else $error("Maker password taken as host password");

   a_pw_default: assert property (@(posedge MCLK) disable iff (RESET)
      $fell(RESET) |-> host_password_r == HOST_PW_DEFAULT)
      else $error("Host password not at default");

   a_pw_keep: assert property (@(posedge MCLK) disable iff (RESET)
      !(change_last && host_pw_ok) |=> $stable(host_password_r))
      else $error("Host password changed without commit");

   a_pw_upper: assert property (@(posedge MCLK) disable iff (RESET)
      (change_last && host_pw_ok) |=>
      host_password_r[30:8] == $past(password_change_area_r[30:8]))
      else $error("Host password upper bytes wrong");

   a_entry_clear: assert property (@(posedge MCLK) disable iff (RESET)
      $fell(RESET) |-> password_entry_area_r == PW_RESET)
      else $error("Entry area not cleared by reset");

   a_page_reset: assert property (@(posedge MCLK) disable iff (RESET)
      $fell(RESET) |-> PAGE == RESET_BYTE
      && upper_page_select_r == RESET_BYTE)
      else $error("Page select not zero after reset");

endmodule // module_ctrl_mask_password_regs

// ---- module_ctrl_mask_password_regs_test.sv ----
/*
 * Self-checking bench for the control, mask and password byte slice.
 * Assumes the host model owns the request port; pins driven from here.
 */
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin n_errors++; \
   $display("wrong value %s exp %h got %h", n, e, s); end end
module module_ctrl_mask_password_regs_test;
   import modctl_pkg::*;
   logic        MCLK = 0, RESET = 1, LP_MODE_PIN = 0, rd_d = 0;
   events_s     EVENTS = '0;
   mgmt_req_s   REQ;
   logic [7:0]  RDATA, PAGE, exp_v, d, mofs;
   logic [3:0]  TX_OFF;
   logic        LOW_POWER, INT_N, USER_PAGE_WRITE_OK;
   logic [31:0] pw;
   logic [7:0]  exp_q[$];
   int          n_errors = 0, n_checks = 0, mbit;
   logic [7:0] mofs_list[6] = '{8'h5d, 8'h7f, 8'h64, 8'h65, 8'h67, 8'h68};

   always #10 MCLK = ~MCLK;

   module_ctrl_mask_password_regs i_module_ctrl_mask_password_regs (
      .MCLK(MCLK), .RESET(RESET), .REQ(REQ), .RDATA(RDATA),
      .LP_MODE_PIN(LP_MODE_PIN), .EVENTS(EVENTS), .TX_OFF(TX_OFF),
      .LOW_POWER(LOW_POWER), .INT_N(INT_N), .PAGE(PAGE),
      .USER_PAGE_WRITE_OK(USER_PAGE_WRITE_OK));
   host_ctl_model i_host_ctl_model (.MCLK(MCLK), .REQ(REQ));

   // Read data stand from the cycle after the strobe until the next read
   always @(posedge MCLK) rd_d <= REQ.rd;
   always @(negedge MCLK) if (rd_d) begin
      exp_v = exp_q.pop_front();
      `CHK("read data", exp_v, RDATA)
   end

   task automatic end_sim;
      if (n_errors == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      i_host_ctl_model.put(a, 8'h00, 1'b0);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      i_host_ctl_model.put(a, v, 1'b1);
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge MCLK);
      @(negedge MCLK);
   endtask

   initial begin
      #100us;
      n_errors++;
      end_sim;
   end

   initial begin
      pw = $urandom(8);
      repeat (5) @(posedge MCLK);
      RESET <= 1'b0;
      foreach (mofs_list[i]) rd(mofs_list[i], 8'h00);
      `CHK("int", 1'b1, INT_N)
      for (int a = 8'h57; a <= 8'h5c; a++) begin
         wr(a[7:0], 8'hff);
         rd(a[7:0], 8'h00);
      end
      d = 8'($urandom);
      wr(8'h56, d);
      rd(8'h56, {4'h0, d[3:0]});
      @(negedge MCLK);
      `CHK("tx off", d[3:0], TX_OFF)
      @(posedge MCLK) LP_MODE_PIN <= 1'b1;
      settle(8);
      `CHK("low power", 1'b1, LOW_POWER)
      wr(8'h5d, 8'h01);
      settle(2);
      `CHK("low power", 1'b0, LOW_POWER)
      wr(8'h5d, 8'h03);
      rd(8'h5d, 8'h03);
      @(posedge MCLK) LP_MODE_PIN <= 1'b0;
      settle(8);
      `CHK("low power", 1'b1, LOW_POWER)
      // Every event source, raised alone, then masked by its own bit
      for (int g = 0; g < 4; g++) for (int b = 0; b < 4; b++) begin
         mofs = mofs_list[g + 2];
         mbit = (g < 2) ? b : b + 4;
         @(posedge MCLK) EVENTS <= events_s'(16'h1 << (12 - 4 * g + b));
         settle(6);
         `CHK("int", 1'b0, INT_N)
         wr(mofs, 8'h01 << mbit);
         rd(mofs, 8'h01 << mbit);
         settle(6);
         `CHK("int", 1'b1, INT_N)
         wr(mofs, 8'h00);
         @(posedge MCLK) EVENTS <= '0;
      end
      // Everything raised at once, everything masked
      wr(8'h64, 8'h0f);
      wr(8'h65, 8'h0f);
      wr(8'h67, 8'hf0);
      wr(8'h68, 8'hf0);
      @(posedge MCLK) EVENTS <= '1;
      settle(6);
      `CHK("int", 1'b1, INT_N)
      wr(8'h64, 8'h00);
      settle(2);
      `CHK("int", 1'b0, INT_N)
      @(posedge MCLK) EVENTS <= '0;
      settle(6);
      `CHK("int", 1'b1, INT_N)
      rd(8'h7b, 8'h00);
      i_host_ctl_model.set_pw(8'h7b, 32'h0000_1011);
      settle(4);
      `CHK("pw ok", 1'b1, USER_PAGE_WRITE_OK)
      rd(8'h6a, 8'h01);
      pw = $urandom | 32'h8000_0000;
      i_host_ctl_model.set_pw(8'h77, pw);
      settle(4);
      `CHK("pw ok", 1'b0, USER_PAGE_WRITE_OK)
      i_host_ctl_model.set_pw(8'h7b, pw);
      settle(4);
      `CHK("pw ok", 1'b0, USER_PAGE_WRITE_OK)
      i_host_ctl_model.set_pw(8'h7b, pw & 32'h7fff_ffff);
      settle(4);
      `CHK("pw ok", 1'b1, USER_PAGE_WRITE_OK)
      d = 8'($urandom);
      wr(8'h7f, d);
      rd(8'h7f, d);
      @(negedge MCLK);
      `CHK("page", d, PAGE)
      `CHK("pw ok", 1'b1, USER_PAGE_WRITE_OK)
      @(posedge MCLK) RESET <= 1'b1;
      repeat (5) @(posedge MCLK);
      RESET <= 1'b0;
      @(negedge MCLK);
      `CHK("pw ok", 1'b0, USER_PAGE_WRITE_OK)
      rd(8'h56, 8'h00);
      i_host_ctl_model.set_pw(8'h7b, 32'h0000_1011);
      settle(4);
      `CHK("pw ok", 1'b1, USER_PAGE_WRITE_OK)
      settle(1);
      end_sim;
   end
endmodule // module_ctrl_mask_password_regs_test
